// *** dv/power_state_supply_config_tb.sv ***
`timescale 1ns/1ns
module power_state_supply_config_tb;
  import pss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dwell_tick, wake_req, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, aw, s1, s2;
  good_s       supply_good;
  supply_s     supply_out;
  int          failures, comparisons, n1, n2, cnt;
  logic [7:0]  ofs [4] = '{8'h14, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rst [4] = '{32'h00100033, 32'h00000033, 32'h00100022, 32'h00100002};

  always #20 pclk = ~pclk;

  power_state_supply_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dwell_tick(dwell_tick), .wake_req(wake_req), .supply_good(supply_good),
    .supply_out(supply_out));
  supply_model rails (.pclk(pclk), .presetn(presetn), .supply_out(supply_out), .supply_good(supply_good));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // analogue enable is hard-wired on in every timed state
  function automatic supply_s outs(input logic [31:0] w);
    return {w[14], w[9], w[8], w[5], w[4], 1'b1, w[0]};
  endfunction : outs

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
    if (i == 16) begin failures++; summarize(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // counts cycles an output pattern stands, after waiting briefly for it
  task automatic span(input supply_s p, output int n);
    int i;
    n = 0; i = 0; #1;
    while (supply_out !== p && i < 8) begin @(posedge pclk); #1; i++; end
    while (supply_out === p && n < 64) begin @(posedge pclk); #1; n++; end
  endtask : span
  task automatic to_awake;
    int i;
    for (i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      dwell_tick <= seed[0];
      apb(STATUS_OFS, 1'b0, 32'h0);
      if (rd[18:16] === 3'h5) break;
    end
    dwell_tick <= 1'b1;
    chk("state code", 32'(rd[18:16]), 32'h5);
  endtask : to_awake

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    dwell_tick = 0; wake_req = 0; seed = 32'hD4410A1F; failures = 0; comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(ofs[i], 1'b0, 32'h0);
      chk("reset word", rd, rst[i]);
    end
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    apb(WAKE2_OFS, 1'b1, 32'h00000033);
    to_awake();
    $display("test wake done");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed); aw = seed & ~32'h4000; n1 = seed[1:0]; n2 = seed[3:2];
      seed = lfsr(seed); s1 = seed & 32'hFFE0FFFF | 32'(n1) << 16 | 32'h4000;
      seed = lfsr(seed); s2 = seed & 32'hFFE0BFFF | 32'(n2) << 16 | 32'h200;
      apb(AWAKE_OFS, 1'b1, aw);
      apb(AWAKE_OFS, 1'b0, 32'h0);
      chk("awake word", rd, aw & 32'h4331 | 32'h2);
      chk("awake outs", 32'(supply_out), 32'(outs(aw)));
      apb(SLEEP1_OFS, 1'b1, s1);
      apb(SLEEP1_OFS, 1'b0, 32'h0);
      chk("sleep1 word", rd, s1 & 32'h001F4331 | 32'h2);
      apb(SLEEP2_OFS, 1'b1, s2);
      apb(CTRL_OFS, 1'b1, 32'h2);
      span(outs(s1), cnt);
      chk("sleep1 span", 32'(cnt), 32'h1 << n1);
      span(outs(s2), cnt);
      chk("sleep2 span", 32'(cnt), 32'h1 << n2);
      chk("asleep outs", 32'(supply_out), 32'(outs(32'h2)));
      apb(CTRL_OFS, 1'b0, 32'h0);
      chk("sleep bit", rd, 32'h0);
      wake_req <= 1'b1;
      to_awake();
      wake_req <= 1'b0;
      $display("test sleep cycle %0d done", k);
    end
    summarize();
  end
endmodule : power_state_supply_config_tb

// *** dv/supply_model.sv ***
`timescale 1ns/1ns
module supply_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire pss_pkg::supply_s supply_out,
  output pss_pkg::good_s        supply_good
);
  import pss_pkg::*;
  logic [3:0] en;
  logic [2:0] ramp_q [4];
  // rails need several cycles to come up, so good never follows enable at once
  assign en = {supply_out.io_supply_output, supply_out.pll_linear_regulator,
               supply_out.analog_buck_converter, supply_out.core_buck_converter};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        ramp_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!en[i]) begin
          ramp_q[i] <= 3'h0;
        end else if (ramp_q[i] != 3'h7) begin
          ramp_q[i] <= ramp_q[i] + 3'h1;
        end
      end
    end
  end
  assign supply_good = {ramp_q[3] == 3'h7, ramp_q[2] == 3'h7, ramp_q[1] == 3'h7, ramp_q[0] == 3'h7};
endmodule : supply_model

// *** rtl/dummy_unused_never.sv ***
`timescale 1ns/1ns

// *** rtl/power_state_supply_config.sv ***
`timescale 1ns/1ns
module power_state_supply_config (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             dwell_tick,
  input  wire logic             wake_req,
  input  wire pss_pkg::good_s   supply_good,
  output pss_pkg::supply_s      supply_out
);
  import pss_pkg::*;

  logic [31:0] wake2_q;
  logic [31:0] awake_q;
  logic [31:0] sleep1_q;
  logic [31:0] sleep2_q;
  logic        sleep_req_q;
  seq_state_e  state_q;
  seq_state_e  state_d;
  logic [31:0] cnt_q;
  logic        dwell_done_q;
  supply_s     supply_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] cur_cfg;
  logic        all_good;
  logic        hit;
  logic        wr_en;
  logic        setup;

  function automatic logic dwell_hit(input logic [31:0] cnt, input logic [31:0] word);
    logic [4:0] n;
    n = word[DWELL_MSB:DWELL_LSB];
    dwell_hit = (cnt == ((ONE_WORD << n) - ONE_WORD));
  endfunction : dwell_hit

  function automatic supply_s cfg_to_supply(input logic [31:0] word);
    supply_s s;
    s.tile_clk_off          = word[TILE_BIT];
    s.analog_pfm            = word[APFM_BIT];
    s.core_pfm              = word[CPFM_BIT];
    s.io_supply_output      = word[IO_BIT];
    s.pll_linear_regulator  = word[PLL_BIT];
    s.analog_buck_converter = word[AEN_BIT];
    s.core_buck_converter   = word[CEN_BIT];
    cfg_to_supply = s;
  endfunction : cfg_to_supply

  // a rail that is switched off cannot hold the exit back
  function automatic logic supplies_good(input supply_s s, input good_s g);
    logic [3:0] en;
    logic [3:0] ok;
    en = {s.io_supply_output, s.pll_linear_regulator, s.analog_buck_converter, s.core_buck_converter};
    ok = {g.io_good, g.pll_good, g.analog_good, g.core_good};
    supplies_good = &(~en | ok);
  endfunction : supplies_good

  // the only legal successor of each state, whatever holds the exit back
  function automatic seq_state_e succ_state(input seq_state_e st);
    seq_state_e nx;
    nx = ST_WAKE_ONE;
    unique case (st)
      ST_RESET:      nx = ST_WAKE_ONE;
      ST_ASLEEP:     nx = ST_WAKE_ONE;
      ST_WAKE_ONE:   nx = ST_WAKE_TWO;
      ST_WAKE_TWO:   nx = ST_AWAKE_WAIT;
      ST_AWAKE_WAIT: nx = ST_AWAKE;
      ST_AWAKE:      nx = ST_SLEEP_ONE;
      ST_SLEEP_ONE:  nx = ST_SLEEP_TWO;
      ST_SLEEP_TWO:  nx = ST_ASLEEP;
    endcase
    succ_state = nx;
  endfunction : succ_state

  // status image: state code plus the live output bits at their word positions
  function automatic logic [31:0] status_word(input seq_state_e st, input supply_s s);
    logic [31:0] w;
    w                    = ZERO_WORD;
    w[STATE_LSB +: 3]    = st;
    w[TILE_BIT]          = s.tile_clk_off;
    w[APFM_BIT]          = s.analog_pfm;
    w[CPFM_BIT]          = s.core_pfm;
    w[IO_BIT]            = s.io_supply_output;
    w[PLL_BIT]           = s.pll_linear_regulator;
    w[AEN_BIT]           = s.analog_buck_converter;
    w[CEN_BIT]           = s.core_buck_converter;
    status_word          = w;
  endfunction : status_word

  function automatic logic [31:0] state_cfg(input seq_state_e  st,
                                            input logic [31:0] w2,
                                            input logic [31:0] aw,
                                            input logic [31:0] s1,
                                            input logic [31:0] s2);
    logic [31:0] w;
    w = aw;
    unique case (st)
      ST_RESET:      w = WAKE1_CFG;
      ST_ASLEEP:     w = ASLEEP_CFG;
      ST_WAKE_ONE:   w = WAKE1_CFG;
      ST_WAKE_TWO:   w = w2;
      ST_AWAKE_WAIT: w = aw;
      ST_AWAKE:      w = aw;
      ST_SLEEP_ONE:  w = s1;
      ST_SLEEP_TWO:  w = s2;
    endcase
    state_cfg = w;
  endfunction : state_cfg

  assign cur_cfg  = state_cfg(state_q, wake2_q, awake_q, sleep1_q, sleep2_q);
  assign hit      = dwell_tick && dwell_hit(cnt_q, cur_cfg);
  // disabled supplies count as good so they never block the exit
  assign all_good = supplies_good(supply_q, supply_good);
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pready_q && pwrite;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:      state_d = ST_WAKE_ONE;
      ST_ASLEEP:     if (wake_req) state_d = ST_WAKE_ONE;
      ST_WAKE_ONE:   if (all_good) state_d = ST_WAKE_TWO;
      ST_WAKE_TWO:   if ((dwell_done_q || hit) && all_good) state_d = ST_AWAKE_WAIT;
      ST_AWAKE_WAIT: state_d = ST_AWAKE;
      ST_AWAKE:      if (sleep_req_q) state_d = ST_SLEEP_ONE;
      ST_SLEEP_ONE:  if (hit) state_d = ST_SLEEP_TWO;
      ST_SLEEP_TWO:  if (hit) state_d = ST_ASLEEP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // counts dwell_tick pulses, not pclk cycles, until the dwell is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= ZERO_WORD;
    end else if (state_d != state_q) begin
      cnt_q <= ZERO_WORD;
    end else if (dwell_tick && !dwell_done_q) begin
      cnt_q <= cnt_q + ONE_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_done_q <= 1'b0;
    end else if (state_d != state_q) begin
      dwell_done_q <= 1'b0;
    end else if (hit) begin
      dwell_done_q <= 1'b1;
    end
  end

  // next-state config keeps outputs aligned with the state on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_q <= cfg_to_supply(WAKE1_CFG);
    end else begin
      supply_q <= cfg_to_supply(state_cfg(state_d, wake2_q, awake_q, sleep1_q, sleep2_q));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake2_q  <= WAKE2_RST;
      awake_q  <= AWAKE_RST;
      sleep1_q <= SLEEP1_RST;
      sleep2_q <= SLEEP2_RST;
    end else if (wr_en) begin
      unique case (paddr)
        WAKE2_OFS:  wake2_q  <= (pwdata & DWELL_WMASK) | FIXED_ONES;
        AWAKE_OFS:  awake_q  <= (pwdata & AWAKE_WMASK) | FIXED_ONES;
        SLEEP1_OFS: sleep1_q <= (pwdata & DWELL_WMASK) | FIXED_ONES;
        SLEEP2_OFS: sleep2_q <= (pwdata & DWELL_WMASK) | FIXED_ONES;
        default: ;
      endcase
    end
  end

  // a software set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_req_q <= 1'b0;
    end else if (wr_en && paddr == CTRL_OFS) begin
      sleep_req_q <= pwdata[SLEEP_BIT];
    end else if (state_q == ST_AWAKE && state_d == ST_SLEEP_ONE) begin
      sleep_req_q <= 1'b0;
    end
  end

  // no wait state: data is fixed in setup, pready rises for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= ZERO_WORD;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= 1'b0;
        prdata_q  <= ZERO_WORD;
        unique case (paddr)
          CTRL_OFS:   prdata_q <= {30'h0, sleep_req_q, 1'b0};
          WAKE2_OFS:  prdata_q <= wake2_q;
          AWAKE_OFS:  prdata_q <= awake_q;
          SLEEP1_OFS: prdata_q <= sleep1_q;
          SLEEP2_OFS: prdata_q <= sleep2_q;
          STATUS_OFS: prdata_q <= status_word(state_q, supply_q);
          default:    pslverr_q <= 1'b1;
        endcase
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign supply_out = supply_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_start: assert property ((state_q == ST_AWAKE && sleep_req_q) |=>
    (state_q == ST_SLEEP_ONE && (!sleep_req_q || $past(wr_en))))
    else $error("sleep request not taken or not cleared");

  a_sleep_clear: assert property ((state_q == ST_SLEEP_ONE && $past(state_q) == ST_AWAKE &&
    !$past(wr_en && paddr == CTRL_OFS)) |-> !sleep_req_q)
    else $error("sleep request left set after sleep start");

  a_awake_hold: assert property ((state_q == ST_AWAKE && !sleep_req_q) |=>
    state_q == ST_AWAKE)
    else $error("awake left without sleep request");

  a_wake_wait: assert property ((state_q == ST_WAKE_TWO && !all_good) |=>
    state_q == ST_WAKE_TWO)
    else $error("second waking left with a bad supply");

  a_wake_exit: assert property ((state_q == ST_WAKE_TWO && state_d != state_q) |->
    (dwell_done_q || hit) && supplies_good(supply_q, supply_good))
    else $error("second waking left before dwell or supplies good");

  a_sleep_exit: assert property ((state_q inside {ST_SLEEP_ONE, ST_SLEEP_TWO} &&
    state_d != state_q) |-> (dwell_tick && cnt_q == (ONE_WORD << cur_cfg[DWELL_MSB:DWELL_LSB]) - ONE_WORD))
    else $error("sleeping phase left at wrong count");

  a_asleep_hold: assert property ((state_q == ST_ASLEEP && !wake_req) |=>
    state_q == ST_ASLEEP)
    else $error("asleep left without wake request");

  a_state_order: assert property ((state_d != state_q) |-> state_d == succ_state(state_q))
    else $error("state step out of order");

  a_dwell_restart: assert property ((state_d != state_q) |=> cnt_q == ZERO_WORD)
    else $error("dwell counter not cleared on entry");

  a_tick_only: assert property ((!dwell_tick && state_d == state_q) |=> $stable(cnt_q))
    else $error("dwell counter moved without a tick");

  a_rail_kept: assert property ((state_q inside {ST_WAKE_TWO, ST_AWAKE, ST_SLEEP_ONE,
    ST_SLEEP_TWO}) |-> ##1 supply_q.analog_buck_converter)
    else $error("analogue converter dropped");

  a_fixed_one: assert property (&{wake2_q[AEN_BIT], awake_q[AEN_BIT], sleep1_q[AEN_BIT],
    sleep2_q[AEN_BIT]})
    else $error("analogue enable bit not held at one");

  a_awake_reserved: assert property ((awake_q & ~(AWAKE_WMASK | FIXED_ONES)) == ZERO_WORD)
    else $error("awake word reserved bits set");

  a_dwell_reserved: assert property (((wake2_q | sleep1_q | sleep2_q) &
    ~(DWELL_WMASK | FIXED_ONES)) == ZERO_WORD)
    else $error("dwell word reserved bits set");

  // output checks skip entry cycles, where the next state's word is loaded instead
  a_tile_gate: assert property ((state_d == state_q) |=>
    supply_q.tile_clk_off == $past(cur_cfg[TILE_BIT]))
    else $error("tile clock gate wrong");

  a_mod_select: assert property ((state_d == state_q) |=>
    {supply_q.analog_pfm, supply_q.core_pfm} == $past(cur_cfg[APFM_BIT:CPFM_BIT]))
    else $error("modulation select wrong");

  a_supply_follow: assert property ((state_d == state_q) |=>
    {supply_q.io_supply_output, supply_q.pll_linear_regulator, supply_q.core_buck_converter}
    == $past({cur_cfg[IO_BIT], cur_cfg[PLL_BIT], cur_cfg[CEN_BIT]}))
    else $error("supply enable wrong");

  // the bus answers in the cycle after setup and only then
  a_ready_pulse: assert property (setup |=> (pready ##1 !pready))
    else $error("ready not a single pulse after setup");

  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  c_full_sleep: cover property (state_q == ST_SLEEP_TWO ##1 state_q == ST_ASLEEP);
  c_wake_done: cover property (state_q == ST_WAKE_TWO ##1 state_q == ST_AWAKE_WAIT);
  c_sleep_go: cover property (state_q == ST_AWAKE ##1 state_q == ST_SLEEP_ONE);
  c_asleep_wake: cover property (state_q == ST_ASLEEP ##1 state_q == ST_WAKE_ONE);
  c_tile_off: cover property (state_q == ST_SLEEP_ONE && supply_q.tile_clk_off);
endmodule : power_state_supply_config

// *** rtl/pss_pkg.sv ***
package pss_pkg;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  WAKE2_OFS   = 8'h14;
  localparam logic [7:0]  AWAKE_OFS   = 8'h18;
  localparam logic [7:0]  SLEEP1_OFS  = 8'h1C;
  localparam logic [7:0]  SLEEP2_OFS  = 8'h20;
  localparam logic [7:0]  STATUS_OFS  = 8'h24;
  localparam int          DWELL_LSB   = 16;
  localparam int          DWELL_MSB   = 20;
  localparam int          STATE_LSB   = 16;
  localparam int          TILE_BIT    = 14;
  localparam int          APFM_BIT    = 9;
  localparam int          CPFM_BIT    = 8;
  localparam int          IO_BIT      = 5;
  localparam int          PLL_BIT     = 4;
  localparam int          AEN_BIT     = 1;
  localparam int          CEN_BIT     = 0;
  localparam int          SLEEP_BIT   = 1;
  localparam logic [31:0] DWELL_WMASK = 32'h001F4331;
  localparam logic [31:0] AWAKE_WMASK = 32'h00004331;
  localparam logic [31:0] FIXED_ONES  = 32'h00000002;
  localparam logic [31:0] WAKE2_RST   = 32'h00100033;
  localparam logic [31:0] AWAKE_RST   = 32'h00000033;
  localparam logic [31:0] SLEEP1_RST  = 32'h00100022;
  localparam logic [31:0] SLEEP2_RST  = 32'h00100002;
  localparam logic [31:0] ASLEEP_CFG  = 32'h00000002;
  localparam logic [31:0] WAKE1_CFG   = 32'h00000022;
  localparam logic [31:0] ZERO_WORD   = 32'h00000000;
  localparam logic [31:0] ONE_WORD    = 32'h00000001;

  typedef enum logic [2:0] {
    ST_RESET      = 3'b000,
    ST_ASLEEP     = 3'b001,
    ST_WAKE_ONE   = 3'b010,
    ST_WAKE_TWO   = 3'b011,
    ST_AWAKE_WAIT = 3'b100,
    ST_AWAKE      = 3'b101,
    ST_SLEEP_ONE  = 3'b110,
    ST_SLEEP_TWO  = 3'b111
  } seq_state_e;

  typedef struct packed {
    logic tile_clk_off;
    logic analog_pfm;
    logic core_pfm;
    logic io_supply_output;
    logic pll_linear_regulator;
    logic analog_buck_converter;
    logic core_buck_converter;
  } supply_s;

  typedef struct packed {
    logic io_good;
    logic pll_good;
    logic analog_good;
    logic core_good;
  } good_s;
endpackage : pss_pkg
